// file: core/udb_pkg.sv
// Constants and types shared by the serial data buffer and its baud timer.
package udb_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] SFR_ADDR_DATA  = 8'h99;
  localparam logic [3:0] SFR_PAGE_DATA  = 4'h0;
  localparam logic [7:0] DATA_RESET     = 8'h00;

  // ---------------------------------------------------------------------
  // Baud timer
  // ---------------------------------------------------------------------
  localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4  = 2'h1;
  localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
  localparam logic [5:0] DIV12_LAST     = 6'h0b;
  localparam logic [5:0] DIV4_LAST      = 6'h03;
  localparam logic [5:0] DIV48_LAST     = 6'h2f;
  localparam logic [7:0] TIMER_TOP      = 8'hff;

  // ---------------------------------------------------------------------
  // Frame shape
  // ---------------------------------------------------------------------
  localparam logic [3:0] BITS_MODE8     = 4'h8;
  localparam logic [3:0] BITS_MODE9     = 4'h9;
  localparam logic [3:0] BITS_NONE      = 4'h0;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_WAIT,
    TX_SHIFT,
    TX_STOP
  } udb_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } udb_rx_state_t;

endpackage

// file: core/udb_baud_gen.sv
// Reloading 8-bit baud timer with its clock prescaler.
`timescale 1ns/1ps
module udb_baud_gen (
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  input  wire logic       i_direct_clk,
  input  wire logic [1:0] i_prescale,
  input  wire logic [7:0] i_reload,
  output logic            o_ovf,
  output logic            o_bit_tick
);

  typedef struct packed {
    logic [5:0] pre_cnt;
    logic [7:0] tmr;
    logic       ovf;
    logic       phase;
    logic       bit_tick;
  } udb_baud_state_t;

  udb_baud_state_t q;
  udb_baud_state_t d;
  logic [5:0]      pre_last;
  logic            tmr_en;

  // Prescale code 11 has no divider of its own; it falls back to 48.
  always_comb begin
    pre_last = udb_pkg::DIV48_LAST;
    case (i_prescale)
      udb_pkg::PRESCALE_DIV12: pre_last = udb_pkg::DIV12_LAST; // [R7]
      udb_pkg::PRESCALE_DIV4:  pre_last = udb_pkg::DIV4_LAST;  // [R7]
      udb_pkg::PRESCALE_DIV48: pre_last = udb_pkg::DIV48_LAST; // [R7]
      default:                 pre_last = udb_pkg::DIV48_LAST;
    endcase
  end

  // Timer counts up from the reload value and reloads at overflow; every
  // second overflow closes one bit period.
  always_comb begin
    d          = q;
    d.ovf      = 1'b0;
    d.bit_tick = 1'b0;
    tmr_en     = i_direct_clk || (q.pre_cnt == pre_last); // [R7]
    if (i_direct_clk || q.pre_cnt >= pre_last) begin
      d.pre_cnt = '0;
    end else begin
      d.pre_cnt = q.pre_cnt + 6'h01;
    end
    if (tmr_en) begin
      if (q.tmr == udb_pkg::TIMER_TOP) begin
        d.tmr      = i_reload;                             // [R8]
        d.ovf      = 1'b1;
        d.phase    = ~q.phase;
        d.bit_tick = q.phase;                              // [R8]
      end else begin
        d.tmr = q.tmr + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_ovf      = q.ovf;
  assign o_bit_tick = q.bit_tick;

endmodule // udb_baud_gen

// file: core/udb_uart_core.sv
// Serial port data buffer with transmitter, receiver and baud timer.
//
// What this block does
// (R1) Byte written to data buffer goes to transmit shifter until sent.
// (R2) Every write to the data buffer starts a new transmission.
// (R3) Reading the data buffer returns the receive latch, not transmit data.
// (R4) Data buffer: one 8-bit location at 0x99, page 0x0, resets zero.
// (R5) At 24.5 MHz software picks direct clock, reloads CB, 96, 2B.
// (R6) At 22.1184 MHz software reloads D0, A0, 40 direct; A0 over 12.
// (R7) Direct clock select bypasses prescale; else 00 /12, 01 /4, 10 /48.
// (R8) Timer overflows every 256 minus reload clocks; two overflows per bit.
// (R9) Nine-bit mode sets transmit flag at start of stop bit; software clears.
// (R10) Receive loads only when flag clear and, if filtering, ninth bit is 1.
// (R11) Nine-bit frame: start, eight data LSB first, ninth bit, stop.
`timescale 1ns/1ps
module udb_uart_core (
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [3:0] i_sfr_page,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_mode_nine_bit,
  input  wire logic       i_multiproc_filter_enable,
  input  wire logic       i_receive_enable_bit,
  input  wire logic       i_tx_ninth_bit,
  input  wire logic       i_tx_flag_clear,
  input  wire logic       i_rx_flag_clear,
  input  wire logic       i_baud_timer_direct_clock_select,
  input  wire logic [1:0] i_timer_prescale_select,
  input  wire logic [7:0] i_baud_reload,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_tx_complete_flag,
  output logic            o_rx_complete_flag,
  output logic            o_rx_ninth_bit
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    udb_pkg::udb_tx_state_t tx_st;
    logic [8:0]             tx_shift;
    logic [3:0]             tx_left;
    logic                   txd;
    logic                   tx_flag;
    udb_pkg::udb_rx_state_t rx_st;
    logic [8:0]             rx_shift;
    logic [3:0]             rx_left;
    logic                   rx_half;
    logic [7:0]             rx_latch;
    logic                   rx_ninth;
    logic                   rx_flag;
    logic [7:0]             rdata;
  } udb_core_state_t;

  udb_core_state_t q;
  udb_core_state_t d;
  logic            ovf;
  logic            bit_tick;
  logic            hit;
  logic [3:0]      nbits;
  logic [7:0]      rx_byte;
  logic            rx_gate_bit;
  logic            rx_tail_bit;

  // -----------------------------------------------------------------------
  // Baud timer
  // -----------------------------------------------------------------------
  // Rates are set purely by software choice of direct clock select, reload and prescale.
  udb_baud_gen u_baud (
    .i_clk_sys    (i_clk_sys),
    .i_arst_n     (i_arst_n),
    .i_direct_clk (i_baud_timer_direct_clock_select),
    .i_prescale   (i_timer_prescale_select),
    .i_reload     (i_baud_reload),
    .o_ovf        (ovf),
    .o_bit_tick   (bit_tick)
  ); // [R5] [R6]

  // -----------------------------------------------------------------------
  // Decode and frame helpers
  // -----------------------------------------------------------------------
  // The buffer answers on one address of one page only.
  assign hit   = (i_sfr_addr == udb_pkg::SFR_ADDR_DATA) &&
                 (i_sfr_page == udb_pkg::SFR_PAGE_DATA);       // [R4]
  assign nbits = i_mode_nine_bit ? udb_pkg::BITS_MODE9
                                 : udb_pkg::BITS_MODE8;        // [R11]

  // In eight-bit mode the data sit one place higher in the shifter, and
  // the stop bit takes the place of the ninth bit.
  always_comb begin
    if (i_mode_nine_bit) begin
      rx_byte     = q.rx_shift[7:0];
      rx_gate_bit = q.rx_shift[8];
    end else begin
      rx_byte     = q.rx_shift[8:1];
      rx_gate_bit = rx_tail_bit;
    end
  end
  assign rx_tail_bit = i_rxd;

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    d = q;

    // Read port: data come from the receive latch, never from transmit.
    if (i_sfr_rd && hit) begin
      d.rdata = q.rx_latch;                                    // [R3]
    end

    // Software clears flags; a hardware set in the same cycle wins below.
    if (i_tx_flag_clear) begin
      d.tx_flag = 1'b0;
    end
    if (i_rx_flag_clear) begin
      d.rx_flag = 1'b0;
    end

    // Transmitter. The start bit waits for the next bit tick so every
    // bit lasts a full period; a write mid-frame restarts with new data.
    case (q.tx_st)
      udb_pkg::TX_IDLE: begin
        d.txd = 1'b1;
      end
      udb_pkg::TX_WAIT: begin
        if (bit_tick) begin
          d.txd     = 1'b0;                                    // [R11]
          d.tx_left = nbits;
          d.tx_st   = udb_pkg::TX_SHIFT;
        end
      end
      udb_pkg::TX_SHIFT: begin
        if (bit_tick) begin
          if (q.tx_left == udb_pkg::BITS_NONE) begin
            d.txd     = 1'b1;
            d.tx_flag = 1'b1;                                  // [R9]
            d.tx_st   = udb_pkg::TX_STOP;
          end else begin
            d.txd      = q.tx_shift[0];                        // [R1] [R11]
            d.tx_shift = {1'b1, q.tx_shift[8:1]};
            d.tx_left  = q.tx_left - 4'h1;
          end
        end
      end
      udb_pkg::TX_STOP: begin
        if (bit_tick) begin
          d.tx_st = udb_pkg::TX_IDLE;
        end
      end
      default: begin
        d.tx_st = udb_pkg::TX_IDLE;
        d.txd   = 1'b1;
      end
    endcase

    if (i_sfr_wr && hit) begin
      d.tx_shift = {i_tx_ninth_bit, i_sfr_wdata};              // [R1]
      d.tx_st    = udb_pkg::TX_WAIT;                           // [R2]
      d.txd      = 1'b1;
    end

    // Receiver. Overflows mark half bits: the first one after the start edge
    // confirms the start, then every second one samples the next bit.
    case (q.rx_st)
      udb_pkg::RX_IDLE: begin
        if (i_receive_enable_bit && !i_rxd) begin
          d.rx_st = udb_pkg::RX_START;
        end
      end
      udb_pkg::RX_START: begin
        if (ovf) begin
          if (!i_rxd) begin
            d.rx_st   = udb_pkg::RX_DATA;
            d.rx_left = nbits;
            d.rx_half = 1'b0;
          end else begin
            d.rx_st = udb_pkg::RX_IDLE;
          end
        end
      end
      udb_pkg::RX_DATA: begin
        if (ovf) begin
          d.rx_half = ~q.rx_half;
          if (q.rx_half) begin
            d.rx_shift = {i_rxd, q.rx_shift[8:1]};             // [R11]
            d.rx_left  = q.rx_left - 4'h1;
            if (q.rx_left == 4'h1) begin
              d.rx_st = udb_pkg::RX_STOP;
            end
          end
        end
      end
      udb_pkg::RX_STOP: begin
        if (ovf) begin
          d.rx_half = ~q.rx_half;
          if (q.rx_half) begin
            d.rx_st = udb_pkg::RX_IDLE;
            if (!q.rx_flag &&
                (!i_multiproc_filter_enable || rx_gate_bit)) begin
              d.rx_latch = rx_byte;                            // [R10]
              d.rx_ninth = i_mode_nine_bit ? q.rx_shift[8]
                                           : rx_tail_bit;
              d.rx_flag  = 1'b1;                               // [R10]
            end
          end
        end
      end
      default: begin
        d.rx_st = udb_pkg::RX_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q          <= '0;
      q.tx_st    <= udb_pkg::TX_IDLE;
      q.rx_st    <= udb_pkg::RX_IDLE;
      q.txd      <= 1'b1;            // Line idles high.
      q.rx_latch <= udb_pkg::DATA_RESET;                       // [R4]
      q.rdata    <= udb_pkg::DATA_RESET;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign o_sfr_rdata        = q.rdata;
  assign o_txd              = q.txd;
  assign o_tx_complete_flag = q.tx_flag;
  assign o_rx_complete_flag = q.rx_flag;
  assign o_rx_ninth_bit     = q.rx_ninth;

endmodule // udb_uart_core

// file: sim/udb_uart_core_asserts.sv
// Port-level checker for the serial data buffer and its baud timer.
`timescale 1ns/1ps
module udb_uart_core_asserts (
  input wire logic       i_clk_sys,
  input wire logic       i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [3:0] i_sfr_page,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_multiproc_filter_enable,
  input wire logic       i_tx_flag_clear,
  input wire logic       i_rx_flag_clear,
  input wire logic       o_txd,
  input wire logic       o_tx_complete_flag,
  input wire logic       o_rx_complete_flag,
  input wire logic       o_rx_ninth_bit
);
  logic hit_a;
  logic wr_hit;
  logic rd_hit;

  // An access counts only at the buffer's own address and page.
  assign hit_a = i_sfr_addr == udb_pkg::SFR_ADDR_DATA
              && i_sfr_page == udb_pkg::SFR_PAGE_DATA;
  assign wr_hit = i_sfr_wr && hit_a;
  assign rd_hit = i_sfr_rd && hit_a;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_rd_hold: assert property (
    !rd_hit |=> $stable(o_sfr_rdata)) else $error("rdata moved");
  a_rd_repeat: assert property (
    rd_hit && o_rx_complete_flag ##1 rd_hit && o_rx_complete_flag
    |=> $stable(o_sfr_rdata)) else $error("latch moved while flagged");
  a_bit_min: assert property (
    $changed(o_txd) && !wr_hit && !$past(wr_hit) |=> $stable(o_txd))
    else $error("bit shorter than two clocks");
  a_txflag_stop: assert property (
    $rose(o_tx_complete_flag) |-> o_txd) else $error("flag not at stop");
  a_txflag_sticky: assert property (
    o_tx_complete_flag && !i_tx_flag_clear |=> o_tx_complete_flag)
    else $error("tx flag dropped");
  a_rxflag_sticky: assert property (
    o_rx_complete_flag && !i_rx_flag_clear |=> o_rx_complete_flag)
    else $error("rx flag dropped");
  a_rx_gate: assert property (
    $rose(o_rx_complete_flag) && i_multiproc_filter_enable
    |-> o_rx_ninth_bit) else $error("filtered frame loaded");
  a_ninth_hold: assert property (
    o_rx_complete_flag |=> $stable(o_rx_ninth_bit))
    else $error("ninth bit loaded while flagged");
endmodule // udb_uart_core_asserts

bind udb_uart_core udb_uart_core_asserts udb_uart_core_asserts_i (
  .i_clk_sys, .i_arst_n, .i_sfr_addr, .i_sfr_page, .i_sfr_wr, .i_sfr_rd,
  .o_sfr_rdata, .i_multiproc_filter_enable, .i_tx_flag_clear,
  .i_rx_flag_clear, .o_txd, .o_tx_complete_flag, .o_rx_complete_flag,
  .o_rx_ninth_bit);

// file: sim/udb_line_model.sv
// Line-side model of the remote serial transceiver.
`timescale 1ns/1ps
module udb_line_model (
  input  wire logic i_clk_sys,
  output logic      o_rxd,
  input  wire logic i_txd
);
  int bit_clks = 8;

  // The line idles high between frames.
  initial o_rxd = 1'b1;

  // Holds one level for a bit period and returns just after an edge.
  task hold(input logic v);
    o_rxd = v;
    repeat (bit_clks) @(posedge i_clk_sys);
    #1;
  endtask

  // Start bit, nb bits LSB first, then stop.
  task send(input logic [8:0] d, input int nb);
    hold(1'b0);
    for (int i = 0; i < nb; i++) hold(d[i]);
    hold(1'b1);
  endtask

  // Samples mid-bit on falling edges, away from the device's updates.
  task get(input int nb, output logic [9:0] d);
    d = 10'h000;
    @(negedge i_txd);
    repeat (bit_clks / 2) @(negedge i_clk_sys);
    for (int i = 0; i <= nb; i++) begin
      repeat (bit_clks) @(negedge i_clk_sys);
      d[i] = i_txd;
    end
  endtask
endmodule // udb_line_model

// file: sim/tb_udb_uart_core.sv
// Self-checking bench for the serial data buffer and baud timer.
`timescale 1ns/1ps
module tb_udb_uart_core;
  logic       i_clk_sys = 1'b0;
  logic       i_arst_n = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
  logic [7:0] i_baud_reload = 8'hfe, o_sfr_rdata;
  logic [3:0] i_sfr_page = 4'h0;
  logic [1:0] i_timer_prescale_select = 2'h0;
  logic       i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_mode_nine_bit = 1'b0;
  logic       i_multiproc_filter_enable = 1'b0, i_receive_enable_bit = 1'b1;
  logic       i_tx_ninth_bit = 1'b0, i_tx_flag_clear = 1'b0;
  logic       i_rx_flag_clear = 1'b0, i_baud_timer_direct_clock_select = 1'b1;
  logic       i_rxd, o_txd, o_tx_complete_flag;
  logic       o_rx_complete_flag, o_rx_ninth_bit;
  logic [9:0] f;
  logic [1:0] ps_t [5] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h3};
  int         n_fail = 0, compares = 0;

  udb_uart_core udb_uart_core_i (.i_clk_sys, .i_arst_n, .i_sfr_addr,
    .i_sfr_page, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
    .i_mode_nine_bit, .i_multiproc_filter_enable, .i_receive_enable_bit,
    .i_tx_ninth_bit, .i_tx_flag_clear, .i_rx_flag_clear,
    .i_baud_timer_direct_clock_select, .i_timer_prescale_select,
    .i_baud_reload, .i_rxd, .o_txd, .o_tx_complete_flag,
    .o_rx_complete_flag, .o_rx_ninth_bit);
  udb_line_model udb_line_model_i (.i_clk_sys, .o_rxd(i_rxd), .i_txd(o_txd));

  // 25 MHz system clock.
  always #20 i_clk_sys = ~i_clk_sys;

  // Inputs always move one nanosecond after the rising edge.
  task tick;
    @(posedge i_clk_sys);
    #1;
  endtask

  task chk(input string s, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask

  // One-cycle write strobe, then a gap so strobes never merge.
  task wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    {i_sfr_addr, i_sfr_page, i_sfr_wdata, i_sfr_wr} = {a, p, d, 1'b1};
    tick;
    i_sfr_wr = 1'b0;
    tick;
  endtask

  // Read strobe held for n cycles; data is checked once settled.
  task rd(input int n, input logic [7:0] e);
    i_sfr_addr = udb_pkg::SFR_ADDR_DATA;
    i_sfr_page = udb_pkg::SFR_PAGE_DATA;
    i_sfr_rd = 1'b1;
    repeat (n) tick;
    i_sfr_rd = 1'b0;
    tick;
    chk("rdata", {2'h0, e}, {2'h0, o_sfr_rdata});
  endtask

  // Bit period in clocks follows the selected timer clock and reload.
  task cfg(input logic dir, input logic [1:0] ps, input logic [7:0] rl,
           input logic m9);
    {i_baud_timer_direct_clock_select, i_timer_prescale_select} = {dir, ps};
    {i_baud_reload, i_mode_nine_bit} = {rl, m9};
    udb_line_model_i.bit_clks = 2 * (256 - int'(rl))
      * (dir ? 1 : ps == 2'h1 ? 4 : ps == 2'h0 ? 12 : 48);
  endtask

  // Sends one byte and checks the frame, the flag and its clearing.
  task tx(input logic [7:0] d, input logic n9, input int nb);
    i_tx_ninth_bit = n9;
    // The start bit may fall before the write task returns, so the line
    // watcher must already be waiting when the strobe goes out.
    fork
      udb_line_model_i.get(nb, f);
      wr(8'h99, 4'h0, d);
    join
    chk("frame", nb == 9 ? {1'b1, n9, d} : {1'b0, 1'b1, d}, f);
    chk("tx flag", 10'h1, {9'h0, o_tx_complete_flag});
    tick;
    i_tx_flag_clear = 1'b1;
    tick;
    i_tx_flag_clear = 1'b0;
    tick;
    chk("tx clear", 10'h0, {9'h0, o_tx_complete_flag});
  endtask

  // Receives one frame of nb bits and checks flag and ninth bit.
  task rx(input logic [8:0] d, input logic fl, input logic nb9,
          input int nb);
    udb_line_model_i.send(d, nb);
    chk("rx flag", {9'h0, fl}, {9'h0, o_rx_complete_flag});
    chk("rx ninth", {9'h0, nb9}, {9'h0, o_rx_ninth_bit});
  endtask

  task give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short well after the expected fifteen thousand cycles.
  initial begin
    #2000000;
    n_fail++;
    give_verdict;
  end

  initial begin
    repeat (8) tick;
    i_arst_n = 1'b1;
    chk("reset", 10'h4, {7'h0, o_txd, o_tx_complete_flag,
        o_rx_complete_flag});
    rd(1, udb_pkg::DATA_RESET);
    cfg(1'b1, 2'h3, 8'hcb, 1'b0);
    tx(8'ha5, 1'b0, 8);
    cfg(1'b1, 2'h0, 8'hcb, 1'b1);
    tx(8'h3c, 1'b1, 9);
    rd(1, 8'h00);
    rx(9'h05a, 1'b1, 1'b0, 9);
    rd(2, 8'h5a);
    rx(9'h177, 1'b1, 1'b0, 9);
    rd(2, 8'h5a);
    i_rx_flag_clear = 1'b1;
    tick;
    {i_rx_flag_clear, i_multiproc_filter_enable} = 2'b01;
    rx(9'h011, 1'b0, 1'b0, 9);
    rx(9'h122, 1'b1, 1'b1, 9);
    rd(1, 8'h22);
    // Eight-bit receive: a disabled receiver ignores the frame, then the
    // stop bit gates the load and lands in the ninth-bit output.
    i_rx_flag_clear = 1'b1;
    tick;
    {i_rx_flag_clear, i_receive_enable_bit} = 2'b00;
    cfg(1'b1, 2'h3, 8'hcb, 1'b0);
    rx(9'h0c3, 1'b0, 1'b1, 8);
    i_receive_enable_bit = 1'b1;
    rx(9'h0c3, 1'b1, 1'b1, 8);
    rd(1, 8'hc3);
    // Writes off the buffer's address or page must not start a frame.
    wr(8'h98, 4'h0, 8'h00);
    wr(8'h99, 4'h1, 8'h00);
    f = 10'h000;
    repeat (250) begin
      tick;
      f[0] = f[0] | ~o_txd;
    end
    chk("no frame", 10'h0, f);
    // Fastest rate of the slower crystal, timer clocked directly.
    cfg(1'b1, 2'h3, 8'hd0, 1'b0);
    tx(8'h96, 1'b0, 8);
    // Every timer clock source, with a stray prescale under direct clock.
    for (int k = 0; k < 5; k++) begin
      cfg(k == 0, ps_t[k], 8'hfe, 1'b0);
      tx(8'h55, 1'b0, 8);
    end
    give_verdict;
  end
endmodule // tb_udb_uart_core
